// ---- dv/sisq_stack_mem_model.sv ----
/*
 * Stack memory on the far side of the sequencer's stack port.
 * Assumes registered one-cycle write strobes on the core clock.
 */
module sisq_stack_mem_model
   import sisq_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic [15:0] mem_addr_in,
   input wire logic mem_we_in,
   input wire logic [7:0] mem_wdata_in,
   input wire logic [15:0] peek_addr_in,
   output logic [7:0] peek_data_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // Byte store; unwritten places stay unknown
   logic [7:0] mem_r [0:511];
   // Keeps only stacked bytes, never the status flags
   always_ff @(posedge core_clk_in) begin
      if (mem_we_in) begin
         mem_r[mem_addr_in[8:0]] <= mem_wdata_in;
      end
   end
   // Bench view of one byte
   assign peek_data_out = mem_r[peek_addr_in[8:0]];
endmodule : sisq_stack_mem_model

// ---- dv/tb.sv ----
/*
 * Self-checking bench of the stack and interrupt sequencer.
 * Assumes the memory model on the stack port; bench plays the pipeline.
 */
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import sisq_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] sop = 3'h0;
   logic done = 1'b0;
   logic sei = 1'b0;
   logic cli = 1'b0;
   logic asleep = 1'b0;
   logic [10:0] pc = 11'h000;
   logic io_wr = 1'b0;
   logic [5:0] io_a = 6'h00;
   logic [7:0] io_d = 8'h00;
   logic st_wr = 1'b0;
   logic [7:0] st_d = 8'h00;
   logic [7:0] cond = 8'h00;
   logic [7:0] level = 8'h00;
   logic [7:0] en = 8'h00;
   logic [7:0] swclr = 8'h00;
   logic [15:0] peek_a = 16'h0000;
   logic [7:0] io_q, m_d, peek_d;
   logic [15:0] sp, m_a;
   logic m_we, m_re, gie, stall, vgo, rgo;
   logic [2:0] vidx;
   int mismatches = 0;
   int n_tests = 0;
   // Free-running core clock, 10 ns
   always #5 clk = ~clk;
   sisq_core i_sisq_core (.core_clk_in(clk), .sys_rst_in(rst),
      .stack_op_in(sop), .insn_done_in(done), .sei_in(sei), .cli_in(cli),
      .asleep_in(asleep), .pc_in(pc), .io_wr_in(io_wr), .io_addr_in(io_a),
      .io_wdata_in(io_d), .io_rdata_out(io_q), .status_wr_in(st_wr),
      .status_wdata_in(st_d), .irq_cond_in(cond), .irq_level_in(level),
      .irq_enable_in(en), .irq_sw_clear_in(swclr), .stack_addr_out(sp),
      .mem_addr_out(m_a), .mem_we_out(m_we), .mem_re_out(m_re),
      .mem_wdata_out(m_d), .global_en_out(gie), .stall_out(stall),
      .vector_go_out(vgo), .vector_idx_out(vidx), .return_go_out(rgo));
   sisq_stack_mem_model i_sisq_stack_mem_model (.core_clk_in(clk),
      .mem_addr_in(m_a), .mem_we_in(m_we), .mem_wdata_in(m_d),
      .peek_addr_in(peek_a), .peek_data_out(peek_d));
   //////////////////////////////////////////////////////////////////////
   // Compare and drive helpers
   task automatic chk_val(input logic [15:0] g, e, input string s);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %0t %s got %h exp %h", $time, s, g, e);
      end
   endtask : chk_val
   task automatic chk_cnt(input int g, e, input string s);
      n_tests++;
      if (g != e) begin
         mismatches++;
         $display("[ERR] %0t %s count %0d exp %0d", $time, s, g, e);
      end
   endtask : chk_cnt
   task automatic tick;
      @(negedge clk);
   endtask : tick
   // Holds one op code for a cycle; next call may follow at once
   task automatic op(input logic [2:0] c);
      sop = c;
      tick;
   endtask : op
   task automatic io_write(input logic [5:0] a, input logic [7:0] d);
      io_a = a;
      io_d = d;
      io_wr = 1'b1;
      tick;
      io_wr = 1'b0;
      // Idle cycle so the next write raises the strobe afresh
      tick;
   endtask : io_write
   task automatic irq_pulse(input int s);
      cond[s] = 1'b1;
      tick;
      cond[s] = 1'b0;
      tick;
   endtask : irq_pulse
   // Counts vectors over n cycles, dropping pulses after the first
   task automatic no_vec(input int n, input string s);
      int seen;
      seen = 0;
      repeat (n) begin
         tick;
         done = 1'b0;
         sei = 1'b0;
         cli = 1'b0;
         if (vgo === 1'b1) seen++;
      end
      chk_cnt(seen, 0, s);
   endtask : no_vec
   // Instruction end that takes an interrupt, then the entry checks
   task automatic take(input logic [10:0] p, input logic [2:0] idx,
                       input int cyc);
      logic [15:0] sp0;
      int k;
      sp0 = sp;
      k = 0;
      pc = p;
      done = 1'b1;
      do begin
         tick;
         done = 1'b0;
         k++;
      end while (vgo !== 1'b1 && k < 20);
      // Boundary cycle, then the entry cycles, then the vector pulse
      chk_cnt(k, cyc + 1, "entry length");
      chk_val(16'(vidx), 16'(idx), "vector");
      chk_val(16'(gie), 16'h0000, "gie entry");
      chk_val(sp, sp0 - 16'h0002, "sp entry");
      peek_a = sp0;
      #1 chk_val(16'(peek_d), 16'(p[7:0]), "pc low");
      peek_a = sp0 - 16'h0001;
      #1 chk_val(16'(peek_d), 16'(p[10:8]), "pc high");
      tick;
   endtask : take
   task automatic interrupt_return;
      logic [15:0] sp0;
      int k;
      sp0 = sp;
      k = 0;
      sop = SISQ_OP_INTERRUPT_RETURN;
      do begin
         tick;
         sop = 3'h0;
         k++;
      end while (rgo !== 1'b1 && k < 20);
      // Op cycle, then the return cycles, then the return pulse
      chk_cnt(k, SISQ_RETURN_CYCLES + 1, "return length");
      chk_val(16'(gie), 16'h0001, "gie return");
      chk_val(sp, sp0 + 16'h0002, "sp return");
   endtask : interrupt_return
   //////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_stack;
      logic [15:0] s0;
      s0 = sp;
      op(SISQ_OP_PUSH);
      chk_val(16'(m_we), 16'h0001, "push strobe");
      chk_val(m_a, s0, "push addr");
      chk_val(sp, s0 - 16'h0001, "sp push");
      op(SISQ_OP_POP);
      chk_val(16'(m_re), 16'h0001, "pop strobe");
      chk_val(m_a, s0, "pop addr");
      chk_val(sp, s0, "sp pop");
      op(SISQ_OP_CALL);
      chk_val(sp, s0 - 16'h0002, "sp call");
      op(SISQ_OP_RET);
      chk_val(sp, s0, "sp ret");
      op(SISQ_OP_NONE);
   endtask : t_stack
   task automatic t_io;
      io_write(SISQ_IO_SP_HIGH, 8'h01);
      io_write(SISQ_IO_SP_LOW, 8'h50);
      io_write(6'h3F, 8'hAA);
      chk_val(sp, 16'h0150, "sp write");
      io_a = SISQ_IO_SP_LOW;
      #1 chk_val(16'(io_q), 16'h0050, "low read");
      io_a = 6'h3F;
      #1 chk_val(16'(io_q), 16'h0000, "unmapped read");
      tick;
   endtask : t_io
   task automatic t_gate;
      en = 8'h02;
      irq_pulse(1);
      done = 1'b1;
      no_vec(8, "gie clear");
      en = 8'h00;
      st_d = 8'h80;
      st_wr = 1'b1;
      tick;
      st_wr = 1'b0;
      done = 1'b1;
      no_vec(8, "source off");
      en = 8'h0A;
      irq_pulse(3);
      take(11'h5A3, 3'h1, 4);
      interrupt_return;
      // First boundary after return must not vector
      done = 1'b1;
      no_vec(4, "after return");
      take(11'h2C4, 3'h3, 4);
      interrupt_return;
      done = 1'b1;
      // Second boundary, past the hold-off after return
      tick;
      no_vec(6, "flags cleared");
   endtask : t_gate
   task automatic t_cli_sei;
      en = 8'h01;
      irq_pulse(0);
      cli = 1'b1;
      done = 1'b1;
      no_vec(8, "cli same cycle");
      chk_val(16'(gie), 16'h0000, "gie cli");
      sei = 1'b1;
      done = 1'b1;
      tick;
      // Instruction after set-enable ends without a vector
      sei = 1'b0;
      no_vec(6, "sei cycle");
      take(11'h7FF, 3'h0, 4);
      interrupt_return;
      irq_pulse(0);
      asleep = 1'b1;
      // One instruction after return before the next entry
      done = 1'b1;
      tick;
      take(11'h123, 3'h0, 8);
      asleep = 1'b0;
      interrupt_return;
   endtask : t_cli_sei
   task automatic t_level;
      en = 8'h00;
      level = 8'h20;
      irq_pulse(5);
      en = 8'h20;
      done = 1'b1;
      // Two boundaries: hold-off from the last return ends first
      tick;
      no_vec(6, "level gone");
      cond[5] = 1'b1;
      take(11'h0F0, 3'h5, 4);
      cond[5] = 1'b0;
      interrupt_return;
      en = 8'h00;
      level = 8'h00;
      irq_pulse(0);
      swclr = 8'h01;
      tick;
      swclr = 8'h00;
      en = 8'h01;
      done = 1'b1;
      // Two boundaries: hold-off from the last return ends first
      tick;
      no_vec(6, "sw clear");
   endtask : t_level
   //////////////////////////////////////////////////////////////////////
   // Verdict and run control
   task automatic final_report;
      $display("mismatches %0d n_tests %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   // Main sequence after a 16-cycle reset
   initial begin
      repeat (16) tick;
      rst = 1'b0;
      chk_val(sp, SISQ_SRAM_LAST_ADDRESS, "sp reset");
      chk_val(16'(gie), 16'h0000, "gie reset");
      io_a = SISQ_IO_SP_HIGH;
      #1 chk_val(16'(io_q), 16'h0001, "high read");
      tick;
      t_stack;
      t_io;
      t_gate;
      t_cli_sei;
      t_level;
      final_report;
   end
   // Watchdog well past the expected run of under two hundred cycles
   initial begin
      #50000;
      mismatches++;
      final_report;
   end
endmodule : tb

// ---- rtl/sisq_core.sv ----
/*
 * Stack pointer and interrupt entry/return sequencer of the core.
 * Assumes the pipeline signals stack ops, instruction ends and I/O
 * accesses one cycle at a time; memory sits outside on the stack port.
 */
//////////////////////////////////////////////////////////////////////////
module sisq_core
   import sisq_pkg::*;
#(
   parameter int NUM_SRC = 8,
   parameter int IDX_W = 3,
   parameter int PC_W = 11
) (
   input wire logic core_clk_in,              // Undivided core clock
   input wire logic sys_rst_in,               // Sync reset, high
   // Pipeline side
   input wire logic [2:0] stack_op_in,        // Stack op this cycle
   input wire logic insn_done_in,             // Instruction boundary
   input wire logic sei_in,                   // Set-enable instruction
   input wire logic cli_in,                   // Clear-enable instruction
   input wire logic asleep_in,                // Core in sleep
   input wire logic [PC_W-1:0] pc_in,         // Return address
   // I/O register port
   input wire logic io_wr_in,                 // I/O write strobe
   input wire logic [5:0] io_addr_in,         // I/O offset
   input wire logic [7:0] io_wdata_in,        // Write data
   output logic [7:0] io_rdata_out,           // Read data
   input wire logic status_wr_in,             // Status flags written
   input wire logic [7:0] status_wdata_in,    // New status flags
   // Interrupt sources
   input wire logic [NUM_SRC-1:0] irq_cond_in,
   input wire logic [NUM_SRC-1:0] irq_level_in,
   input wire logic [NUM_SRC-1:0] irq_enable_in,
   input wire logic [NUM_SRC-1:0] irq_sw_clear_in,
   // Stack memory port
   output logic [15:0] stack_addr_out,        // Current pointer
   output logic [15:0] mem_addr_out,          // Stack access address
   output logic mem_we_out,                   // Stack write strobe
   output logic mem_re_out,                   // Stack read strobe
   output logic [7:0] mem_wdata_out,          // Pushed counter byte
   // Sequencer results
   output logic global_en_out,                // Global enable bit
   output logic stall_out,                    // Pipeline held
   output logic vector_go_out,                // Jump to vector now
   output logic [IDX_W-1:0] vector_idx_out,   // Vector index
   output logic return_go_out                 // Return sequence done
);
   typedef struct packed {
      logic [15:0] sp;            // Stack pointer
      logic gie;                  // Global enable
      sisq_state_e state;         // Sequencer state
      logic [3:0] cnt;            // Cycle in the sequence
      logic [3:0] last;           // Final cycle of entry
      logic [IDX_W-1:0] idx;      // Source being served
      logic block_one;            // Hold off until next boundary
      logic vec_go;               // Vector pulse
      logic ret_go;               // Return pulse
      logic [15:0] maddr;         // Stack access address
      logic mwe;                  // Stack write
      logic mre;                  // Stack read
      logic [7:0] mdata;          // Stack write byte
   } sisq_core_s;

   sisq_core_s st_r;
   sisq_core_s st_nxt;
   logic [NUM_SRC-1:0] pending;
   logic [NUM_SRC-1:0] hw_clear;
   logic any_req;
   logic [IDX_W-1:0] win_idx;
   logic gie_now;
   logic take;
   logic [15:0] pc_ext;

   ////////////////////////////////////////////////////////////////////////
   // Source flags and priority choice
   sisq_irq_flags #(
      .NUM_SRC(NUM_SRC)
   ) u_flags (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .cond_in(irq_cond_in),
      .level_type_in(irq_level_in),
      .sw_clear_in(irq_sw_clear_in),
      .hw_clear_in(hw_clear),
      .pending_out(pending)
   );

   sisq_prio_pick #(
      .NUM_SRC(NUM_SRC),
      .IDX_W(IDX_W)
   ) u_pick (
      .req_in(pending & irq_enable_in),
      .any_out(any_req),
      .idx_out(win_idx)
   );

   ////////////////////////////////////////////////////////////////////////
   // Acceptance decision
   always_comb begin
      // Clear-enable wins in its own cycle
      gie_now = st_r.gie && !cli_in;
      take = (st_r.state == SISQ_ST_RUN) && insn_done_in
             && gie_now && any_req
             && !st_r.block_one && !sei_in;
      pc_ext = 16'(pc_in);
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state of pointer, enable and sequencer
   always_comb begin
      st_nxt = st_r;
      st_nxt.vec_go = 1'b0;
      st_nxt.ret_go = 1'b0;
      st_nxt.mwe = 1'b0;
      st_nxt.mre = 1'b0;
      hw_clear = '0;
      // Hold-off ends once an instruction completes
      if (insn_done_in && st_r.state == SISQ_ST_RUN) begin
         st_nxt.block_one = 1'b0;
      end
      // Software enable changes; hardware never saves flags
      if (cli_in) begin
         st_nxt.gie = 1'b0;
      end else if (sei_in) begin
         st_nxt.gie = 1'b1;
         st_nxt.block_one = 1'b1;
      end else if (status_wr_in) begin
         st_nxt.gie = status_wdata_in[SISQ_GIE_BIT];
      end
      // Pointer byte writes
      if (io_wr_in && io_addr_in == SISQ_IO_SP_LOW) begin
         st_nxt.sp[7:0] = io_wdata_in;
      end else if (io_wr_in && io_addr_in == SISQ_IO_SP_HIGH) begin
         st_nxt.sp[15:8] = io_wdata_in;
      end
      case (st_r.state)
         SISQ_ST_RUN: begin
            if (take) begin
               st_nxt.state = SISQ_ST_ENTRY;
               st_nxt.idx = win_idx;
               st_nxt.cnt = '0;
               st_nxt.last = asleep_in ? SISQ_WAKE_LAST
                                       : SISQ_ENTRY_LAST;
               st_nxt.gie = 1'b0;
               hw_clear[win_idx] = 1'b1;
            end else begin
               case (sisq_op_e'(stack_op_in))
                  SISQ_OP_PUSH: begin
                     // Write at pointer, then step down
                     st_nxt.maddr = st_r.sp;
                     st_nxt.mwe = 1'b1;
                     st_nxt.sp = st_r.sp - 16'h0001;
                  end
                  SISQ_OP_POP: begin
                     // Step up, then read the new top
                     st_nxt.sp = st_r.sp + 16'h0001;
                     st_nxt.maddr = st_r.sp + 16'h0001;
                     st_nxt.mre = 1'b1;
                  end
                  SISQ_OP_CALL: begin
                     st_nxt.sp = st_r.sp - 16'h0002;
                  end
                  SISQ_OP_RET: begin
                     st_nxt.sp = st_r.sp + 16'h0002;
                  end
                  SISQ_OP_INTERRUPT_RETURN: begin
                     st_nxt.state = SISQ_ST_RETURN;
                     st_nxt.cnt = '0;
                  end
                  default: begin
                  end
               endcase
            end
         end
         SISQ_ST_ENTRY: begin
            // Cycles 0 and 1 push the counter low then high byte
            st_nxt.cnt = st_r.cnt + 4'h1;
            if (st_r.cnt < 4'h2) begin
               st_nxt.maddr = st_r.sp;
               st_nxt.mwe = 1'b1;
               st_nxt.mdata = (st_r.cnt == 4'h0) ? pc_ext[7:0]
                                                 : pc_ext[15:8];
               st_nxt.sp = st_r.sp - 16'h0001;
            end
            if (st_r.cnt == st_r.last) begin
               st_nxt.state = SISQ_ST_RUN;
               st_nxt.vec_go = 1'b1;
            end
         end
         SISQ_ST_RETURN: begin
            // Cycles 0 and 1 pop two bytes
            st_nxt.cnt = st_r.cnt + 4'h1;
            if (st_r.cnt < 4'h2) begin
               st_nxt.sp = st_r.sp + 16'h0001;
               st_nxt.maddr = st_r.sp + 16'h0001;
               st_nxt.mre = 1'b1;
            end
            if (st_r.cnt == SISQ_RETURN_LAST) begin
               st_nxt.state = SISQ_ST_RUN;
               st_nxt.gie = 1'b1;
               st_nxt.block_one = 1'b1;
               st_nxt.ret_go = 1'b1;
            end
         end
         default: begin
            st_nxt.state = SISQ_ST_RUN;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // State register on the undivided core clock
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         st_r <= '0;
         st_r.sp <= SISQ_SRAM_LAST_ADDRESS;
         st_r.state <= SISQ_ST_RUN;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   always_comb begin
      case (io_addr_in)
         SISQ_IO_SP_LOW: io_rdata_out = st_r.sp[7:0];
         SISQ_IO_SP_HIGH: io_rdata_out = st_r.sp[15:8];
         default: io_rdata_out = 8'h00;
      endcase
   end
   assign stack_addr_out = st_r.sp;
   assign mem_addr_out = st_r.maddr;
   assign mem_we_out = st_r.mwe;
   assign mem_re_out = st_r.mre;
   assign mem_wdata_out = st_r.mdata;
   assign global_en_out = st_r.gie;
   assign stall_out = (st_r.state != SISQ_ST_RUN);
   assign vector_go_out = st_r.vec_go;
   assign vector_idx_out = st_r.idx;
   assign return_go_out = st_r.ret_go;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_entry_start;
      st_r.state == SISQ_ST_RUN && take && !asleep_in;
   endsequence
   sequence s_vector_out;
      ##4 vector_go_out;
   endsequence

   chk_push_down: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      (!take && st_r.state == SISQ_ST_RUN && stack_op_in == 3'h1
       && !io_wr_in) |=> stack_addr_out == $past(stack_addr_out) - 16'h1)
      else $error("push did not lower pointer by one");
   chk_pop_up: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      (!take && st_r.state == SISQ_ST_RUN && stack_op_in == 3'h2
       && !io_wr_in) |=> mem_re_out && mem_addr_out == stack_addr_out)
      else $error("pop read wrong address");
   chk_call_two: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      (!take && st_r.state == SISQ_ST_RUN && stack_op_in == 3'h3
       && !io_wr_in) |=> stack_addr_out == $past(stack_addr_out) - 16'h2)
      else $error("call did not lower pointer by two");
   chk_entry_four: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      s_entry_start |=> s_vector_out)
      else $error("entry not four cycles");
   chk_entry_gie: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      take |=> !global_en_out [*4])
      else $error("global enable not cleared on entry");
   chk_cli_block: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      cli_in |-> !take)
      else $error("interrupt taken with clear-enable");
   chk_gie_gate: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      !global_en_out |-> !take)
      else $error("interrupt taken while disabled");
   chk_interrupt_return_four: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      (st_r.state == SISQ_ST_RUN && !take && stack_op_in == 3'h5)
      |=> ##4 (return_go_out && global_en_out
               && stack_addr_out == $past(stack_addr_out, 5) + 16'h2))
      else $error("return not four cycles or pointer wrong");
   chk_ret_hold: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      return_go_out |-> !take)
      else $error("interrupt taken right after return");
endmodule : sisq_core

// ---- rtl/sisq_irq_flags.sv ----
/*
 * Pending flags for the interrupt sources, one per source.
 * Assumes condition pulses synchronous to the core clock.
 */
module sisq_irq_flags
   import sisq_pkg::*;
#(
   parameter int NUM_SRC = 8
) (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic [NUM_SRC-1:0] cond_in,        // Raw conditions
   input wire logic [NUM_SRC-1:0] level_type_in,  // 1: level source
   input wire logic [NUM_SRC-1:0] sw_clear_in,    // Write-one clear
   input wire logic [NUM_SRC-1:0] hw_clear_in,    // Vectored source
   output logic [NUM_SRC-1:0] pending_out         // Request per source
);
   typedef struct packed {
      logic [NUM_SRC-1:0] flag;
   } sisq_flags_s;

   sisq_flags_s st_r;
   sisq_flags_s st_nxt;

   ////////////////////////////////////////////////////////////////////////
   // Flag next state: a set wins over a clear in the same cycle
   always_comb begin
      st_nxt = st_r;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (cond_in[i] && !level_type_in[i]) begin
            st_nxt.flag[i] = 1'b1;
         end else if (sw_clear_in[i] || hw_clear_in[i]) begin
            st_nxt.flag[i] = 1'b0;
         end
      end
   end

   // Flag registers
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Level sources request only while the condition stands
   for (genvar g = 0; g < NUM_SRC; g++) begin : g_req
      assign pending_out[g] = level_type_in[g] ? cond_in[g]
                                               : st_r.flag[g];
   end

   chk_flag_held: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      (cond_in[0] && !level_type_in[0]) |=> st_r.flag[0])
      else $error("edge flag not set by its condition");
   chk_wr1_clear: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      (sw_clear_in[0] && !cond_in[0]) |=> !st_r.flag[0])
      else $error("write one did not clear flag");
endmodule : sisq_irq_flags

// ---- rtl/sisq_pkg.sv ----
/*
 * Shared constants and types of the stack and interrupt sequencer.
 * Assumes one 100 MHz core clock and a synchronous active-high reset.
 */
package sisq_pkg;
   // I/O offsets of the stack pointer bytes
   localparam logic [5:0] SISQ_IO_SP_LOW = 6'h3D;
   localparam logic [5:0] SISQ_IO_SP_HIGH = 6'h3E;
   // Data-space offset of the I/O window
   localparam logic [7:0] SISQ_IO_DATA_BASE = 8'h20;
   // Reset value of the pointer: last SRAM address
   localparam logic [15:0] SISQ_SRAM_LAST_ADDRESS = 16'h015F;
   // Global enable bit position in the status flags
   localparam int SISQ_GIE_BIT = 7;
   // Clock period, entry and return lengths
   localparam int SISQ_CLK_PERIOD_NS = 10;
   localparam int SISQ_ENTRY_CYCLES = 4;
   localparam int SISQ_RETURN_CYCLES = 4;
   localparam int SISQ_WAKE_EXTRA_CYCLES = 4;
   localparam logic [3:0] SISQ_ENTRY_LAST = 4'(SISQ_ENTRY_CYCLES - 1);
   localparam logic [3:0] SISQ_WAKE_LAST =
      4'(SISQ_ENTRY_CYCLES + SISQ_WAKE_EXTRA_CYCLES - 1);
   localparam logic [3:0] SISQ_RETURN_LAST = 4'(SISQ_RETURN_CYCLES - 1);
   // Stack operation codes from the pipeline
   typedef enum logic [2:0] {
      SISQ_OP_NONE = 3'h0,
      SISQ_OP_PUSH = 3'h1,
      SISQ_OP_POP = 3'h2,
      SISQ_OP_CALL = 3'h3,
      SISQ_OP_RET = 3'h4,
      SISQ_OP_INTERRUPT_RETURN = 3'h5
   } sisq_op_e;
   // Sequencer states
   typedef enum logic [1:0] {
      SISQ_ST_RUN = 2'h0,
      SISQ_ST_ENTRY = 2'h1,
      SISQ_ST_RETURN = 2'h2,
      SISQ_ST_HOLD = 2'h3
   } sisq_state_e;
endpackage : sisq_pkg

// ---- rtl/sisq_prio_pick.sv ----
/*
 * Fixed priority picker: the lowest index wins.
 * Assumes index 0 is the lowest vector after reset.
 */
module sisq_prio_pick
   import sisq_pkg::*;
#(
   parameter int NUM_SRC = 8,
   parameter int IDX_W = 3
) (
   input wire logic [NUM_SRC-1:0] req_in,  // Enabled requests
   output logic any_out,                    // Some request stands
   output logic [IDX_W-1:0] idx_out        // Winning index
);
   ////////////////////////////////////////////////////////////////////////
   // Scan from the top so the lowest index is kept last
   always_comb begin
      any_out = 1'b0;
      idx_out = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (req_in[i]) begin
            any_out = 1'b1;
            idx_out = IDX_W'(i);
         end
      end
   end
endmodule : sisq_prio_pick
